// ---- hdl/i2cm_pkg.sv ----
// constants, types and register map of the i2c master with fifos
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package i2cm_pkg;

  localparam logic [7:0] ADDR_MODE    = 8'he8;
  localparam logic [7:0] ADDR_TARGET  = 8'he9;
  localparam logic [7:0] ADDR_STATUS  = 8'hea;
  localparam logic [7:0] ADDR_TXBUF   = 8'h9a;
  localparam logic [7:0] ADDR_RXBUF   = 8'h9b;

  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] TARGET_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO    = 8'h00;

  localparam int MODE_EN_BIT  = 7;
  localparam int MODE_DIV_HI  = 6;
  localparam int MODE_DIV_LO  = 5;
  localparam int MODE_CNT_HI  = 4;
  localparam int MODE_CNT_LO  = 0;
  localparam int TGT_RW_BIT   = 0;

  localparam int ST_NOACK = 6;
  localparam int ST_RXP   = 5;
  localparam int ST_TXE   = 4;
  localparam int ST_ACC   = 1;
  localparam int ST_WERR  = 0;

  localparam logic [1:0] LVL_EMPTY = 2'h0;
  localparam logic [1:0] LVL_HALF  = 2'h2;
  localparam logic [1:0] LVL_FULL  = 2'h3;

  localparam int DATA_W         = 8;
  localparam int FIFO_DEPTH     = 4;
  localparam int SCL_BASE_DIV   = 16;
  localparam int PHASES_PER_BIT = 4;

  localparam logic [3:0] ACK_BIT   = 4'h8;
  localparam logic [1:0] PH_SETUP  = 2'h0;
  localparam logic [1:0] PH_RISE   = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_FALL   = 2'h3;

  typedef enum logic [5:0] {
    ENG_IDLE  = 6'h01,
    ENG_START = 6'h02,
    ENG_ADDR  = 6'h04,
    ENG_WDATA = 6'h08,
    ENG_RDATA = 6'h10,
    ENG_STOP  = 6'h20
  } i2cm_eng_type;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } i2cm_sfr_req_type;

endpackage : i2cm_pkg

// ---- hdl/i2cm_fifo.sv ----
// small synchronous fifo with flush, used for transmit and receive bytes
`timescale 1ns/1ns
module i2cm_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          i_clock,
  input  wire logic          i_rst,
  input  wire logic          i_flush,
  input  wire logic          i_push_valid,
  output logic               o_push_ready,
  input  wire logic [W-1:0]  i_push_data,
  output logic               o_pop_valid,
  input  wire logic          i_pop_ready,
  output logic [W-1:0]       o_pop_data,
  output logic [CW-1:0]      o_count
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } i2cm_fifo_state_type;

  i2cm_fifo_state_type q;
  i2cm_fifo_state_type d;
  logic                push;
  logic                pop;

  assign o_push_ready = (q.cnt != CW'(DEPTH));
  assign o_pop_valid  = (q.cnt != '0);
  assign o_pop_data   = q.mem[q.rp];
  assign o_count      = q.cnt;
  assign push         = i_push_valid & o_push_ready;
  assign pop          = i_pop_ready & o_pop_valid;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = i_push_data;
      d.wp        = q.wp + PW'(1);
    end
    if (pop) begin
      d.rp = q.rp + PW'(1);
    end
    d.cnt = q.cnt + CW'(push) - CW'(pop);
    // flush drops everything, including a push in the same cycle
    if (i_flush) begin
      d.wp  = '0;
      d.rp  = '0;
      d.cnt = '0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : i2cm_fifo

// ---- hdl/i2cm_skid.sv ----
// two-entry buffer between receive shifter and receive fifo
`timescale 1ns/1ns
module i2cm_skid #(
  parameter int W = 8
) (
  input  wire logic          i_clock,
  input  wire logic          i_rst,
  input  wire logic          i_valid,
  output logic               o_ready,
  input  wire logic [W-1:0]  i_data,
  output logic               o_valid,
  input  wire logic          i_ready,
  output logic [W-1:0]       o_data
);
  typedef struct packed {
    logic [W-1:0] e0;
    logic [W-1:0] e1;
    logic [1:0]   cnt;
  } i2cm_skid_state_type;

  i2cm_skid_state_type q;
  i2cm_skid_state_type d;

  assign o_ready = (q.cnt != 2'h2);
  assign o_valid = (q.cnt != 2'h0);
  assign o_data  = q.e0;

  always_comb begin
    d = q;
    if (o_valid & i_ready) begin
      d.e0  = q.e1;
      d.cnt = q.cnt - 2'h1;
    end
    if (i_valid & o_ready) begin
      if (d.cnt == 2'h0) begin
        d.e0 = i_data;
      end else begin
        d.e1 = i_data;
      end
      d.cnt = d.cnt + 2'h1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : i2cm_skid

// ---- hdl/i2cm_top.sv ----
// i2c master with transmit and receive fifos behind the sfr port
`timescale 1ns/1ns
module i2cm_top (
  input  wire logic                       i_clock,
  input  wire logic                       i_rst,
  input  wire i2cm_pkg::i2cm_sfr_req_type i_sfr,
  output logic [7:0]                      o_sfr_rdata,
  input  wire logic                       i_rx_irq_on_full,
  input  wire logic                       i_scl_in,
  input  wire logic                       i_sda_in,
  output logic                            o_scl_out,
  output logic                            o_scl_oe,
  output logic                            o_sda_out,
  output logic                            o_sda_oe,
  output logic                            o_irq_req,
  output logic                            o_busy
);
  import i2cm_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH + 1);

  typedef struct packed {
    logic [7:0]   mode;
    logic [7:0]   target;
    logic [7:0]   xfer_tgt; // address byte of the transfer on the wire
    logic         busy;
    logic         noack;
    logic         rxp;
    logic         txe;
    logic         acc_err;
    logic         wr_err;
    logic         tx_empty_prev;
    logic         restart_pend;
    i2cm_eng_type eng;
    logic [3:0]   bitn;
    logic [1:0]   ph;
    logic [7:0]   shift;
    logic [4:0]   rxn;
    logic         ack_seen;
    logic [6:0]   div;
    logic         tick;
    logic         scl_m;
    logic         scl_s;
    logic         sda_m;
    logic         sda_s;
    logic         scl_oe;
    logic         sda_oe;
    logic         pin_low;
    logic [7:0]   rdata;
    logic         irq;
  } i2cm_top_state_type;

  localparam i2cm_top_state_type TOP_RESET = '{
    mode:          MODE_RESET,
    target:        TARGET_RESET,
    eng:           ENG_IDLE,
    tx_empty_prev: 1'b1,
    scl_m:         1'b1,
    scl_s:         1'b1,
    sda_m:         1'b1,
    sda_s:         1'b1,
    default:       '0
  };

  i2cm_top_state_type q;
  i2cm_top_state_type d;

  logic [6:0]    reload;
  logic [4:0]    rct;
  logic          stall_scl;
  logic          push_slot;
  logic          adv;
  logic          rx_push;
  logic          byte_end;
  logic          tx_flush;
  logic          tx_pop;
  logic          tx_wr;
  logic          tgt_wr;
  logic          sts_wr;
  logic          is_i2c_addr;
  logic          skid_in_rdy;
  logic          skid_out_vld;
  logic [7:0]    skid_out_data;
  logic          rxf_in_rdy;
  logic          rxf_vld;
  logic [7:0]    rxf_data;
  logic [CW-1:0] rxf_cnt;
  logic          rx_pop;
  logic          txf_in_rdy;
  logic          txf_vld;
  logic [7:0]    txf_data;
  logic [CW-1:0] txf_cnt;

  //----------------------------------------------------------------------------
  // fifos and receive buffer
  //----------------------------------------------------------------------------
  i2cm_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .i_clock      (i_clock),
    .i_rst        (i_rst),
    .i_flush      (tx_flush),
    .i_push_valid (tx_wr),
    .o_push_ready (txf_in_rdy),
    .i_push_data  (i_sfr.wdata),
    .o_pop_valid  (txf_vld),
    .i_pop_ready  (tx_pop),
    .o_pop_data   (txf_data),
    .o_count      (txf_cnt)
  );

  i2cm_skid #(.W(DATA_W)) u_rx_skid (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_valid (rx_push),
    .o_ready (skid_in_rdy),
    .i_data  (q.shift),
    .o_valid (skid_out_vld),
    .i_ready (rxf_in_rdy),
    .o_data  (skid_out_data)
  );

  i2cm_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .i_clock      (i_clock),
    .i_rst        (i_rst),
    .i_flush      (1'b0),
    .i_push_valid (skid_out_vld),
    .o_push_ready (rxf_in_rdy),
    .i_push_data  (skid_out_data),
    .o_pop_valid  (rxf_vld),
    .i_pop_ready  (rx_pop),
    .o_pop_data   (rxf_data),
    .o_count      (rxf_cnt)
  );

  //----------------------------------------------------------------------------
  // decode and engine strobes
  //----------------------------------------------------------------------------
  // quarter-bit period, four phases per scl period
  assign reload = 7'((SCL_BASE_DIV / PHASES_PER_BIT) << q.mode[MODE_DIV_HI:MODE_DIV_LO])
                  - 7'h01;
  assign rct         = q.mode[MODE_CNT_HI:MODE_CNT_LO];
  assign is_i2c_addr = (i_sfr.addr == ADDR_MODE) | (i_sfr.addr == ADDR_TARGET)
                     | (i_sfr.addr == ADDR_STATUS) | (i_sfr.addr == ADDR_TXBUF)
                     | (i_sfr.addr == ADDR_RXBUF);
  assign tx_wr  = i_sfr.wr & (i_sfr.addr == ADDR_TXBUF);
  assign tgt_wr = i_sfr.wr & (i_sfr.addr == ADDR_TARGET);
  assign sts_wr = i_sfr.wr & (i_sfr.addr == ADDR_STATUS);
  assign rx_pop = i_sfr.rd & (i_sfr.addr == ADDR_RXBUF) & rxf_vld;

  // wait for scl to be seen high, so a slave may stretch the clock
  assign stall_scl = (q.ph == PH_SAMPLE) & !q.scl_s;
  // a received byte waits with scl low until the buffer has room
  assign push_slot = (q.eng == ENG_RDATA) & (q.bitn == ACK_BIT) & (q.ph == PH_SETUP);
  assign adv       = q.tick & (q.eng != ENG_IDLE) & !stall_scl & !(push_slot & !skid_in_rdy);
  assign rx_push   = adv & push_slot;
  assign byte_end  = adv & (q.bitn == ACK_BIT) & (q.ph == PH_FALL)
                   & ((q.eng == ENG_ADDR) | (q.eng == ENG_WDATA));
  assign tx_flush  = byte_end & !q.ack_seen;
  assign tx_pop    = byte_end & q.ack_seen
                   & !((q.eng == ENG_ADDR) & q.xfer_tgt[TGT_RW_BIT]);

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------
  always_comb begin
    logic reading;
    logic set_noack;
    logic rx_evt;
    logic [1:0] lvl;
    logic [CW-1:0] act_cnt;
    reading   = (q.eng == ENG_RDATA);
    set_noack = 1'b0;
    rx_evt    = 1'b0;
    lvl       = LVL_EMPTY;
    act_cnt   = '0;
    d         = q;
    d.tick    = 1'b0;
    d.scl_m   = i_scl_in;
    d.scl_s   = q.scl_m;
    d.sda_m   = i_sda_in;
    d.sda_s   = q.sda_m;
    if (q.div == 7'h00) begin
      d.div  = reload;
      d.tick = 1'b1;
    end else begin
      d.div = q.div - 7'h01;
    end
    if (i_sfr.wr & (i_sfr.addr == ADDR_MODE)) begin
      d.mode = i_sfr.wdata;
    end
    if (tgt_wr) begin
      d.target = i_sfr.wdata;
    end

    if (adv) begin
      d.ph = q.ph + 2'h1;
      case (q.eng)
        ENG_START: begin
          case (q.ph)
            PH_SETUP:  d.sda_oe = 1'b0;
            PH_RISE:   d.scl_oe = 1'b0;
            PH_SAMPLE: d.sda_oe = 1'b1;
            default: begin
              d.scl_oe = 1'b1;
              d.shift  = q.xfer_tgt;
              d.bitn   = '0;
              d.rxn    = '0;
              d.eng    = ENG_ADDR;
            end
          endcase
        end
        ENG_ADDR, ENG_WDATA, ENG_RDATA: begin
          case (q.ph)
            PH_SETUP: begin
              if (q.bitn == ACK_BIT) begin
                // master ack, released on the last byte
                d.sda_oe = reading & (q.rxn != rct);
              end else begin
                d.sda_oe = !reading & !q.shift[7];
              end
            end
            PH_RISE: d.scl_oe = 1'b0;
            PH_SAMPLE: begin
              if (q.bitn == ACK_BIT) begin
                d.ack_seen = !q.sda_s;
              end else begin
                d.shift = {q.shift[6:0], reading & q.sda_s};
              end
            end
            default: begin
              d.scl_oe = 1'b1;
              if (q.bitn != ACK_BIT) begin
                d.bitn = q.bitn + 4'h1;
              end else begin
                d.bitn = '0;
                if (!reading & !q.ack_seen) begin
                  set_noack = 1'b1;
                  d.eng     = ENG_STOP;
                end else if ((q.eng == ENG_ADDR) & q.xfer_tgt[TGT_RW_BIT]) begin
                  d.eng = ENG_RDATA;
                end else if (reading & (q.rxn != rct)) begin
                  d.rxn = q.rxn + 5'h01;
                end else if (!reading & txf_vld) begin
                  d.shift = txf_data;
                  d.eng   = ENG_WDATA;
                end else begin
                  // end of read count or transmit underrun
                  d.eng          = q.restart_pend ? ENG_START : ENG_STOP;
                  d.restart_pend = 1'b0;
                  d.xfer_tgt     = q.target;
                end
              end
            end
          endcase
        end
        ENG_STOP: begin
          case (q.ph)
            PH_SETUP:  d.sda_oe = 1'b1;
            PH_RISE:   d.scl_oe = 1'b0;
            PH_SAMPLE: d.sda_oe = 1'b0;
            default: begin
              if (q.restart_pend) begin
                d.eng          = ENG_START;
                d.restart_pend = 1'b0;
                d.xfer_tgt     = q.target;
              end else begin
                d.eng  = ENG_IDLE;
                d.busy = 1'b0;
              end
            end
          endcase
        end
        default: d.eng = ENG_IDLE;
      endcase
    end

    // launch after the engine so a write in its last cycle is kept
    if (tgt_wr & q.mode[MODE_EN_BIT]) begin
      if (d.eng == ENG_IDLE) begin
        d.eng      = ENG_START;
        d.xfer_tgt = i_sfr.wdata;
        d.ph       = PH_SETUP;
        d.busy = 1'b1;
      end else begin
        d.restart_pend = 1'b1;
      end
    end

    //--------------------------------------------------------------------------
    // status flags: write 0 clears, write 1 keeps, set beats clear
    //--------------------------------------------------------------------------
    rx_evt = skid_out_vld & rxf_in_rdy
           & (!i_rx_irq_on_full | (rxf_cnt == CW'(FIFO_DEPTH - 1)));
    d.tx_empty_prev = (txf_cnt == '0);
    d.noack   = (q.noack & !(sts_wr & !i_sfr.wdata[ST_NOACK])) | set_noack;
    d.rxp     = (q.rxp & !(sts_wr & !i_sfr.wdata[ST_RXP])) | rx_evt;
    d.txe     = (q.txe & !(sts_wr & !i_sfr.wdata[ST_TXE]))
              | ((txf_cnt == '0) & !q.tx_empty_prev);
    d.acc_err = (q.acc_err & !(sts_wr & !i_sfr.wdata[ST_ACC]))
              | (i_sfr.wr & i_sfr.rd & is_i2c_addr);
    d.wr_err  = (q.wr_err & !(sts_wr & !i_sfr.wdata[ST_WERR]))
              | (tx_wr & !txf_in_rdy);
    d.irq     = d.noack | d.rxp | d.txe;

    act_cnt = q.target[TGT_RW_BIT] ? rxf_cnt : txf_cnt;
    lvl     = (act_cnt == '0) ? LVL_EMPTY
            : ((act_cnt == CW'(FIFO_DEPTH)) ? LVL_FULL : LVL_HALF);

    //--------------------------------------------------------------------------
    // read data, registered one cycle after the strobe
    //--------------------------------------------------------------------------
    if (i_sfr.rd) begin
      case (i_sfr.addr)
        ADDR_MODE:   d.rdata = q.mode;
        ADDR_TARGET: d.rdata = q.target;
        ADDR_STATUS: d.rdata = {q.busy, q.noack, q.rxp, q.txe, lvl, q.acc_err, q.wr_err};
        ADDR_RXBUF:  d.rdata = rxf_vld ? rxf_data : READ_ZERO;
        default:     d.rdata = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      q <= TOP_RESET;
    end else begin
      q <= d;
    end
  end

  assign o_sfr_rdata = q.rdata;
  assign o_scl_out   = q.pin_low;
  assign o_sda_out   = q.pin_low;
  assign o_scl_oe    = q.scl_oe;
  assign o_sda_oe    = q.sda_oe;
  assign o_irq_req   = q.irq;
  assign o_busy      = q.busy;
endmodule : i2cm_top

// ---- testbench/i2cm_monitor.sv ----
// checker that watches the i2c master top ports
`timescale 1ns/1ns
module i2cm_monitor (
  input wire logic                       i_clock,
  input wire logic                       i_rst,
  input wire i2cm_pkg::i2cm_sfr_req_type i_sfr,
  input wire logic [7:0]                 o_sfr_rdata,
  input wire logic                       o_scl_oe,
  input wire logic                       o_sda_oe,
  input wire logic                       o_irq_req,
  input wire logic                       o_busy
);
  import i2cm_pkg::*;
  logic       en_q;
  logic [1:0] div_q;
  int         low_q;
  logic       tgt_wr;
  logic       st_rd;
  assign tgt_wr = i_sfr.wr && i_sfr.addr == ADDR_TARGET;
  assign st_rd  = i_sfr.rd && i_sfr.addr == ADDR_STATUS;
  // mirrors enable and divider, counts cycles with scl pulled low
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      en_q  <= 1'b0;
      div_q <= 2'h0;
      low_q <= 0;
    end else begin
      if (i_sfr.wr && i_sfr.addr == ADDR_MODE) begin
        en_q  <= i_sfr.wdata[MODE_EN_BIT];
        div_q <= i_sfr.wdata[MODE_DIV_HI:MODE_DIV_LO];
      end
      low_q <= o_scl_oe ? low_q + 1 : 0;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  a_launch_sets_busy: assert property (tgt_wr && en_q && !o_busy |-> ##[1:2] o_busy)
    else $error("target write did not start a transfer");
  a_off_no_launch: assert property (tgt_wr && !en_q && !o_busy |=> !o_busy)
    else $error("transfer started while disabled");
  a_busy_bit_mirror: assert property (st_rd |=> o_sfr_rdata[7] == $past(o_busy))
    else $error("status busy bit differs from busy output");
  a_level_not_reserved: assert property (st_rd |=> o_sfr_rdata[3:2] != 2'h1)
    else $error("reserved fifo level code");
  a_irq_from_flags: assert property (st_rd |=> o_irq_req == |o_sfr_rdata[ST_NOACK:ST_TXE])
    else $error("interrupt request differs from flags");
  a_start_follows: assert property ($rose(o_busy) |-> ##[1:600] (o_sda_oe && !o_scl_oe))
    else $error("no start condition after launch");
  a_idle_lines_free: assert property (!o_busy && !$past(o_busy) |-> !o_scl_oe && !o_sda_oe)
    else $error("bus lines pulled while idle");
  a_scl_low_time: assert property ($fell(o_scl_oe) |-> low_q >= (4 << div_q))
    else $error("scl low phase too short");
  a_rdata_holds: assert property (!i_sfr.rd |=> $stable(o_sfr_rdata))
    else $error("read data changed without a read");
endmodule : i2cm_monitor

bind i2cm_top i2cm_monitor u_i2cm_monitor (.i_clock(i_clock), .i_rst(i_rst), .i_sfr(i_sfr),
  .o_sfr_rdata(o_sfr_rdata), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe),
  .o_irq_req(o_irq_req), .o_busy(o_busy));

// ---- testbench/i2cm_slave.sv ----
// behavioural i2c slave answering the master on the shared lines
`timescale 1ns/1ns
module i2cm_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2c
) (
  input  wire logic i_clock,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_pull,
  output logic      o_sda_pull
);
  logic [7:0] wq [0:15];
  logic       ack_log [0:15];
  logic [7:0] sh = 8'h00;
  logic [7:0] rb = 8'hc3;
  logic       scl_p = 1'b1;
  logic       sda_p = 1'b1;
  logic       active = 1'b0;
  logic       first = 1'b0;
  logic       rmode = 1'b0;
  int         wn, an, nack_at, stretch, hold, bitn, n_start, n_stop;
  initial begin
    o_scl_pull = 1'b0;
    o_sda_pull = 1'b0;
  end
  // samples the wires away from the master's update edge
  always @(negedge i_clock) begin
    if (scl_p && i_scl && sda_p && !i_sda) begin
      n_start++;
      active = 1'b1;
      first = 1'b1;
      rmode = 1'b0;
      bitn = 0;
    end else if (scl_p && i_scl && !sda_p && i_sda) begin
      n_stop++;
      active = 1'b0;
    end else if (active && !scl_p && i_scl) begin
      if (bitn < 8)
        sh = {sh[6:0], i_sda};
      else if (rmode && !first) begin
        ack_log[an] = i_sda;
        an++;
        rb++;
      end
      bitn++;
    end else if (active && scl_p && !i_scl) begin
      // data only changes while scl is low
      hold = stretch;
      if (bitn == 8 && first) begin
        active = sh[7:1] == DEV_ADDR;
        rmode = sh[0];
        o_sda_pull = active;
      end else if (bitn == 8) begin
        if (!rmode) begin
          wq[wn] = sh;
          wn++;
        end
        o_sda_pull = !rmode && wn != nack_at;
      end else if (bitn == 9) begin
        o_sda_pull = rmode && (first || !ack_log[an - 1]) && !rb[7];
        active = !rmode || first || !ack_log[an - 1];
        first = 1'b0;
        bitn = 0;
      end else if (rmode && !first)
        o_sda_pull = !rb[7 - bitn];
    end
    if (hold > 0)
      hold--;
    o_scl_pull = hold > 0;
    scl_p = i_scl;
    sda_p = i_sda;
  end
endmodule : i2cm_slave

// ---- testbench/i2cm_top_test.sv ----
// self-checking bench for the i2c master with fifos
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module i2cm_top_test;
  import i2cm_pkg::*;
  localparam logic [6:0] DEV = 7'h2c;
  logic             i_clock = 1'b0;
  logic             i_rst = 1'b1;
  logic             irq_full = 1'b0;
  i2cm_sfr_req_type i_sfr = '0;
  logic [7:0]       o_sfr_rdata, rd_v;
  logic             scl_oe, sda_oe, o_busy, scl_pull, sda_pull, scl_w, sda_w;
  logic             scl_out, sda_out, irq;
  int               bad_count, n_tests, cyc;
  assign scl_w = (scl_oe ? scl_out : 1'b1) && !scl_pull;
  assign sda_w = (sda_oe ? sda_out : 1'b1) && !sda_pull;
  i2cm_top u_i2cm_top (.i_clock(i_clock), .i_rst(i_rst), .i_sfr(i_sfr),
    .o_sfr_rdata(o_sfr_rdata), .i_rx_irq_on_full(irq_full), .i_scl_in(scl_w),
    .i_sda_in(sda_w), .o_scl_out(scl_out), .o_scl_oe(scl_oe), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .o_irq_req(irq), .o_busy(o_busy));
  i2cm_slave #(.DEV_ADDR(DEV)) u_i2cm_slave (.i_clock(i_clock), .i_scl(scl_w),
    .i_sda(sda_w), .o_scl_pull(scl_pull), .o_sda_pull(sda_pull));
  always #10 i_clock = ~i_clock;
  //----------------------------------------------------------------------------
  // register access
  //----------------------------------------------------------------------------
  task automatic go(input logic [7:0] a, input logic w, input logic r, input logic [7:0] d);
    @(negedge i_clock);
    i_sfr = '{a, w, r, d};
    @(negedge i_clock);
    i_sfr = '0;
    rd_v = o_sfr_rdata;
  endtask : go
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    go(a, 1'b1, 1'b0, d);
  endtask : wr
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    go(a, 1'b0, 1'b1, 8'h00);
    `CHK(rd_v, e)
  endtask : chk_rd
  task automatic wait_idle;
    repeat (2) @(negedge i_clock);
    `CHK(o_busy, 1'b1)
    for (int k = 0; k < 8000 && o_busy; k++) @(negedge i_clock);
    `CHK(o_busy, 1'b0)
  endtask : wait_idle
  //----------------------------------------------------------------------------
  // scenarios
  //----------------------------------------------------------------------------
  task automatic t_reset;
    chk_rd(ADDR_MODE, MODE_RESET);
    chk_rd(ADDR_TARGET, TARGET_RESET);
    chk_rd(8'h55, READ_ZERO);
    go(ADDR_STATUS, 1'b1, 1'b1, 8'hff);
    chk_rd(ADDR_STATUS, 8'h02);
    wr(ADDR_STATUS, 8'h00);
    chk_rd(ADDR_STATUS, 8'h00);
  endtask : t_reset
  task automatic t_disabled;
    wr(ADDR_TARGET, {DEV, 1'b0});
    repeat (3) @(negedge i_clock);
    `CHK(o_busy, 1'b0)
    chk_rd(ADDR_TARGET, {DEV, 1'b0});
  endtask : t_disabled
  task automatic t_write;
    wr(ADDR_MODE, 8'h80);
    for (int k = 0; k < 5; k++) wr(ADDR_TXBUF, 8'h10 + 8'(k));
    chk_rd(ADDR_STATUS, 8'h0d);
    wr(ADDR_TARGET, {DEV, 1'b0});
    wait_idle();
    `CHK(u_i2cm_slave.wn, 4)
    for (int k = 0; k < 4; k++) `CHK(u_i2cm_slave.wq[k], 8'h10 + 8'(k))
    `CHK(u_i2cm_slave.n_stop, 1)
    chk_rd(ADDR_STATUS, 8'h11);
    wr(ADDR_STATUS, 8'hfe);
    chk_rd(ADDR_STATUS, 8'h10);
    wr(ADDR_STATUS, 8'h00);
    chk_rd(ADDR_STATUS, 8'h00);
  endtask : t_write
  task automatic t_noack;
    u_i2cm_slave.nack_at = 6;
    for (int k = 0; k < 3; k++) wr(ADDR_TXBUF, 8'h20 + 8'(k));
    wr(ADDR_TARGET, {DEV, 1'b0});
    wait_idle();
    `CHK(u_i2cm_slave.wn, 6)
    `CHK(irq, 1'b1)
    chk_rd(ADDR_STATUS, 8'h50);
    wr(ADDR_STATUS, 8'hbf);
    chk_rd(ADDR_STATUS, 8'h10);
    wr(ADDR_STATUS, 8'h00);
    `CHK(irq, 1'b0)
    u_i2cm_slave.nack_at = 0;
  endtask : t_noack
  task automatic t_read;
    u_i2cm_slave.stretch = 20;
    wr(ADDR_MODE, 8'ha2);
    wr(ADDR_TARGET, {DEV, 1'b1});
    wait_idle();
    `CHK(u_i2cm_slave.an, 3)
    for (int k = 0; k < 3; k++) `CHK(u_i2cm_slave.ack_log[k], k == 2)
    chk_rd(ADDR_STATUS, 8'h28);
    for (int k = 0; k < 3; k++) chk_rd(ADDR_RXBUF, 8'hc3 + 8'(k));
    chk_rd(ADDR_RXBUF, READ_ZERO);
    chk_rd(ADDR_STATUS, 8'h20);
    wr(ADDR_STATUS, 8'h00);
  endtask : t_read
  task automatic t_restart;
    irq_full = 1'b1;
    u_i2cm_slave.stretch = 0;
    wr(ADDR_MODE, 8'h80);
    wr(ADDR_TXBUF, 8'h3c);
    wr(ADDR_TARGET, {DEV, 1'b0});
    repeat (4) @(negedge i_clock);
    wr(ADDR_TARGET, {DEV, 1'b1});
    wait_idle();
    `CHK(u_i2cm_slave.n_start, 5)
    `CHK(u_i2cm_slave.n_stop, 4)
    `CHK(u_i2cm_slave.wq[6], 8'h3c)
    chk_rd(ADDR_STATUS, 8'h18);
    chk_rd(ADDR_RXBUF, 8'hc6);
  endtask : t_restart
  task automatic summarize;
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(negedge i_clock);
    i_rst = 1'b0;
    t_reset();
    t_disabled();
    t_write();
    t_noack();
    t_read();
    t_restart();
    summarize();
  end
endmodule : i2cm_top_test
